// [hdl/cstsio_div.sv]
`timescale 1ns/100ps
module cstsio_div
  import cstsio_pkg::*;
#(
  parameter int DW = CSTSIO_DIV_W,
  parameter int BASE = CSTSIO_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Rate select and run gate
  input wire logic [2:0] sel,
  input wire logic run,
  // Half-period enable pulse
  output logic tick
);
  logic [DW-1:0] cnt_q;
  logic [DW-1:0] limit;

  assign limit = DW'((BASE << sel) - 1);

  // Restart on every stop so the first half period is full length
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= '0;
    else if (!run || cnt_q >= limit)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  assign tick = run && (cnt_q >= limit);
endmodule : cstsio_div

// [hdl/cstsio_pkg.sv]
package cstsio_pkg;

  // Register byte offsets on the bus
  localparam logic [3:0] CSTSIO_OFS_CTRL = 4'h0;
  localparam logic [3:0] CSTSIO_OFS_DATA = 4'h4;
  localparam logic [3:0] CSTSIO_OFS_STAT = 4'h8;
  localparam logic [3:0] CSTSIO_OFS_IDLE = 4'hC;
  localparam int CSTSIO_AW = 4;

  // Control register fields
  localparam int CSTSIO_CTRL_START = 7;
  localparam int CSTSIO_CTRL_ABORT = 6;
  localparam int CSTSIO_CTRL_MODE_HI = 5;
  localparam int CSTSIO_CTRL_MODE_LO = 4;
  localparam int CSTSIO_CTRL_ONE = 3;
  localparam int CSTSIO_CTRL_SCK_HI = 2;
  localparam logic [2:0] CSTSIO_SCK_EXT = 3'h7;
  localparam logic [2:0] CSTSIO_SCK_RST = 3'h0;

  // Transfer modes
  localparam logic [1:0] CSTSIO_MODE_TX = 2'h0;
  localparam logic [1:0] CSTSIO_MODE_TXRX = 2'h2;
  localparam logic [1:0] CSTSIO_MODE_RX = 2'h3;

  // Status fields, fixed ones elsewhere
  localparam int CSTSIO_STAT_XFER = 3;
  localparam int CSTSIO_STAT_SHIFT = 2;
  localparam logic [7:0] CSTSIO_STAT_ONES = 8'hF3;

  // Idle control fields
  localparam int CSTSIO_IDLE_RUN = 6;
  localparam int CSTSIO_IDLE_SPARE = 0;
  localparam logic [7:0] CSTSIO_IDLE_ONES = 8'hBE;

  // Serial clock: half period of select 0, doubled per step
  localparam int CSTSIO_CLK_MHZ = 100;
  localparam int CSTSIO_HALF_NS = 80;
  localparam int CSTSIO_HALF_CYC = (CSTSIO_HALF_NS * CSTSIO_CLK_MHZ) / 1000;
  localparam int CSTSIO_DIV_W = 12;

  localparam int CSTSIO_BITS = 8;

  typedef enum logic [1:0] {
    CSTSIO_ST_IDLE,
    CSTSIO_ST_RUN,
    CSTSIO_ST_WAIT
  } cstsio_state_t;

endpackage : cstsio_pkg

// [hdl/cstsio_sync.sv]
`timescale 1ns/100ps
module cstsio_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Levels in and out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  // Each pin gets its own two-stage chain
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        meta_q[i] <= 1'b1;
        sync_o[i] <= 1'b1;
      end
      else
      begin
        meta_q[i] <= async_i[i];
        sync_o[i] <= meta_q[i];
      end
    end
  end
endmodule : cstsio_sync

// [hdl/cstsio_top.sv]
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// Operation
// - Status bit 3 shows transfer in progress
// - Status bit 2 shows shifting in progress
// - Idle bit 6 keeps unit running in idle
// - Clock select 111 picks external clock
// - Internal clock: seven rates driven on pin
// - Internal clock: pin high at transfer start
// - Internal clock: stall until software catches up
// - External clock: far party's pin clock shifts
// - Transmit bit changes on falling pin edge
// - Receive samples on rising pin edge
// - Mode field picks transmit, receive or both
// - Data loaded first; start moves it to shifter
// - Eight bits out, least significant first
// - Buffer load empties buffer, raises interrupt in transmit-only mode
// - Internal clock: no data, clock waits
// - Previous last bit held until first fall
// - Start cleared: finish data, then flag clears
// - Abort set: stop at once, flag clears
// - External clock: late refill sends dummy byte
// - Data reads return receive store only
module cstsio_top
  import cstsio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [CSTSIO_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Chip low-power state
  input wire logic chip_idle,
  // Serial pins
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  output logic serial_data_out_pin,
  input wire logic serial_data_in_pin,
  // Event to the processor
  output logic transfer_interrupt
);

  cstsio_state_t state_q;
  logic ack_q;
  logic req;
  logic wr_en;
  logic rd_en;
  logic transfer_start_bit_q;
  logic forced_abort_bit_q;
  logic [1:0] transfer_mode_select_q;
  logic [2:0] sck_sel_q;
  logic idle_run_enable_q;
  logic idle_spare_q;
  logic [7:0] tx_buf_q;
  logic tx_full_q;
  logic [7:0] rx_buf_q;
  logic rx_full_q;
  logic [7:0] tx_sh_q;
  logic [7:0] rx_sh_q;
  logic [2:0] bit_q;
  logic dummy_q;
  logic sck_q;
  logic sdo_q;
  logic irq_q;
  logic sck_prev_q;
  logic [1:0] pins_s;
  logic sck_s;
  logic sdi_s;
  logic tick;
  logic ext_clk;
  logic unit_run;
  logic fall;
  logic rise;
  logic last_rise;
  logic uses_tx;
  logic uses_rx;
  logic can_go;
  logic wr_ctrl;
  logic wr_data;
  logic rd_data;
  logic start_req;
  logic load_tx;
  logic rx_done;

  // Bus handshake: one wait cycle, then the answer
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign wr_en = avs_write && ack_q;
  assign rd_en = avs_read && ack_q;
  assign wr_ctrl = wr_en && (avs_address == CSTSIO_OFS_CTRL);
  assign wr_data = wr_en && (avs_address == CSTSIO_OFS_DATA);
  assign rd_data = rd_en && (avs_address == CSTSIO_OFS_DATA);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ack_q <= 1'b0;
    else
      ack_q <= req && !ack_q;
  end

  // Read data settles during the wait cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      avs_readdata <= '0;
    else if (req && !ack_q)
    begin
      avs_readdata <= '0;
      case (avs_address)
        CSTSIO_OFS_CTRL:
          avs_readdata[7:0] <= {transfer_start_bit_q, forced_abort_bit_q,
                                transfer_mode_select_q, 1'b1, sck_sel_q};
        CSTSIO_OFS_DATA:
          avs_readdata[7:0] <= rx_buf_q;
        CSTSIO_OFS_STAT:
        begin
          avs_readdata[7:0] <= CSTSIO_STAT_ONES;
          avs_readdata[CSTSIO_STAT_XFER] <= state_q != CSTSIO_ST_IDLE;
          avs_readdata[CSTSIO_STAT_SHIFT] <= state_q == CSTSIO_ST_RUN;
        end
        CSTSIO_OFS_IDLE:
        begin
          avs_readdata[7:0] <= CSTSIO_IDLE_ONES;
          avs_readdata[CSTSIO_IDLE_RUN] <= idle_run_enable_q;
          avs_readdata[CSTSIO_IDLE_SPARE] <= idle_spare_q;
        end
        default:
          avs_readdata <= '0;
      endcase
    end
  end

  // Control register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      transfer_start_bit_q <= 1'b0;
      forced_abort_bit_q <= 1'b0;
      transfer_mode_select_q <= CSTSIO_MODE_TX;
      sck_sel_q <= CSTSIO_SCK_RST;
    end
    else if (wr_ctrl)
    begin
      transfer_start_bit_q <= avs_writedata[CSTSIO_CTRL_START];
      forced_abort_bit_q <= avs_writedata[CSTSIO_CTRL_ABORT];
      transfer_mode_select_q <=
        avs_writedata[CSTSIO_CTRL_MODE_HI:CSTSIO_CTRL_MODE_LO];
      sck_sel_q <= avs_writedata[CSTSIO_CTRL_SCK_HI:0];
    end
  end

  // Idle control register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      idle_run_enable_q <= 1'b0;
      idle_spare_q <= 1'b0;
    end
    else if (wr_en && (avs_address == CSTSIO_OFS_IDLE))
    begin
      idle_run_enable_q <= avs_writedata[CSTSIO_IDLE_RUN];
      idle_spare_q <= avs_writedata[CSTSIO_IDLE_SPARE];
    end
  end

  // Whole shift path freezes in idle unless allowed
  assign unit_run = !chip_idle || idle_run_enable_q;
  assign ext_clk = sck_sel_q == CSTSIO_SCK_EXT;
  assign uses_tx = transfer_mode_select_q != CSTSIO_MODE_RX;
  assign uses_rx = transfer_mode_select_q == CSTSIO_MODE_RX ||
                   transfer_mode_select_q == CSTSIO_MODE_TXRX;

  cstsio_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_i({serial_data_in_pin, serial_clock_pin_i}),
    .sync_o(pins_s)
  );
  assign sck_s = pins_s[0];
  assign sdi_s = pins_s[1];

  cstsio_div u_div (
    .clk(clk),
    .resetn(resetn),
    .sel(sck_sel_q),
    .run(unit_run && !ext_clk && state_q == CSTSIO_ST_RUN),
    .tick(tick)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sck_prev_q <= 1'b1;
    else
      sck_prev_q <= sck_s;
  end

  // Edges from our own divider or from the far party's pin
  always_comb
  begin
    fall = 1'b0;
    rise = 1'b0;
    if (unit_run && state_q == CSTSIO_ST_RUN)
    begin
      if (ext_clk)
      begin
        fall = sck_prev_q && !sck_s;
        rise = !sck_prev_q && sck_s;
      end
      else
      begin
        fall = tick && sck_q;
        rise = tick && !sck_q;
      end
    end
  end

  assign last_rise = rise && (bit_q == 3'(CSTSIO_BITS - 1));

  // Internal clock: continue only once software has caught up
  always_comb
  begin
    can_go = 1'b1;
    if (uses_tx && !tx_full_q)
      can_go = 1'b0;
    if (uses_rx && rx_full_q)
      can_go = 1'b0;
  end

  assign start_req = wr_ctrl && avs_writedata[CSTSIO_CTRL_START] &&
                     !avs_writedata[CSTSIO_CTRL_ABORT] &&
                     state_q == CSTSIO_ST_IDLE;
  assign rx_done = last_rise && uses_rx;

  // Buffer moves into the shifter at start of each byte
  always_comb
  begin
    load_tx = 1'b0;
    if (uses_tx && tx_full_q && transfer_start_bit_q && unit_run)
    begin
      if (state_q == CSTSIO_ST_WAIT && (ext_clk || can_go))
        load_tx = 1'b1;
      if (last_rise)
        load_tx = 1'b1;
    end
  end

  // Transfer sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= CSTSIO_ST_IDLE;
      dummy_q <= 1'b0;
    end
    else if (wr_ctrl && avs_writedata[CSTSIO_CTRL_ABORT])
    begin
      state_q <= CSTSIO_ST_IDLE;
      dummy_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        CSTSIO_ST_IDLE:
        begin
          dummy_q <= 1'b0;
          if (start_req)
            state_q <= CSTSIO_ST_WAIT;
        end
        CSTSIO_ST_WAIT:
        begin
          if (!transfer_start_bit_q)
            state_q <= CSTSIO_ST_IDLE;
          else if (unit_run && (can_go || (ext_clk && !uses_tx)))
            state_q <= CSTSIO_ST_RUN;
          else if (unit_run && ext_clk && load_tx)
            state_q <= CSTSIO_ST_RUN;
        end
        CSTSIO_ST_RUN:
        begin
          if (last_rise)
          begin
            if (!transfer_start_bit_q || dummy_q)
              state_q <= CSTSIO_ST_IDLE;
            else if (ext_clk)
            begin
              // Late refill: one dummy byte, then stop
              if (uses_tx && !tx_full_q)
                dummy_q <= 1'b1;
            end
            else if (!load_tx || (uses_rx && rx_full_q))
              state_q <= CSTSIO_ST_WAIT;
          end
        end
        default:
          state_q <= CSTSIO_ST_IDLE;
      endcase
    end
  end

  // Bit counter advances on each receive-side edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bit_q <= '0;
    else if (state_q == CSTSIO_ST_IDLE)
      bit_q <= '0;
    else if (rise)
      bit_q <= bit_q + 1'b1;
  end

  // Internal serial clock: high at start and while stalled
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sck_q <= 1'b1;
    else if (state_q != CSTSIO_ST_RUN)
      sck_q <= 1'b1;
    else if (fall || rise)
      sck_q <= !sck_q;
  end

  assign serial_clock_pin_o = sck_q;
  assign serial_clock_pin_oe = !ext_clk;

  // Transmit buffer; a write landing with a load keeps it full
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_buf_q <= '0;
      tx_full_q <= 1'b0;
    end
    else if (wr_data)
    begin
      tx_buf_q <= avs_writedata[7:0];
      tx_full_q <= 1'b1;
    end
    else if (load_tx)
      tx_full_q <= 1'b0;
  end

  // Shifter loads; the pin keeps its old bit until the first fall
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tx_sh_q <= '0;
    else if (load_tx)
      tx_sh_q <= tx_buf_q;
  end

  // Bit index picks the next bit, lowest first
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sdo_q <= 1'b1;
    else if (fall && uses_tx)
      sdo_q <= tx_sh_q[bit_q];
  end

  assign serial_data_out_pin = sdo_q;

  // Receive shifter, lowest bit arrives first
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rx_sh_q <= '0;
    else if (rise && uses_rx)
      rx_sh_q <= {sdi_s, rx_sh_q[7:1]};
  end

  // Receive store; a completed byte wins over a same-cycle read
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_buf_q <= '0;
      rx_full_q <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_buf_q <= {sdi_s, rx_sh_q[7:1]};
      rx_full_q <= 1'b1;
    end
    else if (rd_data)
      rx_full_q <= 1'b0;
  end

  // One-cycle event: buffer empty in transmit, byte in otherwise
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_q <= 1'b0;
    else if (uses_rx)
      irq_q <= rx_done;
    else
      irq_q <= load_tx;
  end

  assign transfer_interrupt = irq_q;

endmodule : cstsio_top

// [testbench/cstsio_peer.sv]
`timescale 1ns/100ps
module cstsio_peer
(
  // Pin levels
  input wire logic sck,
  input wire logic sdo,
  output logic ext_sck,
  output logic din,
  // Bench control and results
  input wire logic ext_run,
  input wire logic flush,
  output logic [7:0] rx_byte,
  output int rx_count
);
  logic [7:0] sh;
  logic [7:0] pat = 8'h96;
  logic [2:0] bit_n = 3'h0;
  assign din = pat[0];
  initial rx_count = 0;
  // Clock stands high between frames
  initial
  begin
    ext_sck = 1'b1;
    forever
    begin
      #40;
      ext_sck = ext_run ? !ext_sck : 1'b1;
    end
  end
  always @(negedge sck)
    pat = {pat[0], pat[7:1]};
  // Late sample covers the device's pin synchroniser lag
  always @(posedge sck)
  begin
    #30;
    sh = {sdo, sh[7:1]};
    bit_n = bit_n + 3'h1;
    if (bit_n == 3'h0)
    begin
      rx_byte = sh;
      rx_count++;
    end
  end
  // Reset drives the pin high from unknown, a false rise; recount at release
  always @(negedge flush)
    bit_n = 3'h0;
endmodule : cstsio_peer

// [testbench/cstsio_top_sva.sv]
`timescale 1ns/100ps
module cstsio_top_sva
  import cstsio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register bus
  input wire logic [CSTSIO_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and event
  input wire logic chip_idle,
  input wire logic serial_clock_pin_i,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_out_pin,
  input wire logic serial_data_in_pin,
  input wire logic transfer_interrupt
);
  logic acc, wr_ctl, rd_st, idl_q;
  logic [2:0] sel_q;
  logic [9:0] low_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  assign acc = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_ctl = acc & avs_write & (avs_address == CSTSIO_OFS_CTRL);
  assign rd_st = acc & avs_read & (avs_address == CSTSIO_OFS_STAT);
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      sel_q <= CSTSIO_SCK_RST;
    else if (wr_ctl)
      sel_q <= avs_writedata[2:0];
  // Idle freeze stretches a low phase, so such phases are not timed
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      low_q <= 10'h000;
      idl_q <= 1'b0;
    end
    else
    begin
      low_q <= serial_clock_pin_o ? 10'h000 : low_q + 10'h001;
      idl_q <= serial_clock_pin_o ? 1'b0 : (idl_q | chip_idle);
    end
  a_low_rate: assert property ($rose(serial_clock_pin_o) &&
    serial_clock_pin_oe && !idl_q |-> low_q == (10'h008 << sel_q))
    else $error("serial clock low phase has wrong length");
  a_sdo_fall: assert property ($changed(serial_data_out_pin) &&
    serial_clock_pin_oe |-> !serial_clock_pin_o || !$past(serial_clock_pin_o))
    else $error("data out changed away from a falling clock");
  a_irq_pulse: assert property (transfer_interrupt |=>
    !transfer_interrupt) else $error("interrupt longer than one cycle");
  a_irq_high: assert property (transfer_interrupt &&
    serial_clock_pin_oe |-> serial_clock_pin_o)
    else $error("byte loaded while serial clock low");
  a_oe_select: assert property (wr_ctl |=> serial_clock_pin_oe ==
    ($past(avs_writedata[2:0]) != CSTSIO_SCK_EXT))
    else $error("clock pin enable does not follow select");
  a_abort_quiet: assert property (wr_ctl &&
    avs_writedata[CSTSIO_CTRL_ABORT] && avs_writedata[2:0] != CSTSIO_SCK_EXT
    |-> ##2 (serial_clock_pin_o && !transfer_interrupt) [*4])
    else $error("activity after forced abort");
  a_stat_fixed: assert property (rd_st |-> avs_readdata[31:8] == 24'h0 &&
    (avs_readdata[7:0] | 8'h0C) == 8'hFF) else $error("status fixed bits");
  a_shift_xfer: assert property (rd_st && avs_readdata[2] |->
    avs_readdata[3]) else $error("shift flag without transfer flag");
  a_idle_fixed: assert property (acc && avs_read &&
    avs_address == CSTSIO_OFS_IDLE |-> avs_readdata[31:8] == 24'h0 &&
    (avs_readdata[7:0] | 8'h41) == 8'hFF) else $error("idle fixed bits");
  c_irq: cover property ($rose(transfer_interrupt));
  c_abort: cover property (wr_ctl && avs_writedata[CSTSIO_CTRL_ABORT]);
  c_ext: cover property ($fell(serial_clock_pin_oe));
endmodule : cstsio_top_sva

bind cstsio_top cstsio_top_sva u_cstsio_top_sva (.*);

// [testbench/cstsio_top_test.sv]
`timescale 1ns/100ps
module cstsio_top_test;
  import cstsio_pkg::*;
  logic clk, resetn, rd, wr, wait_r, chip_idle, sck_o, oe, sdo, din, irq;
  logic ext_sck, ext_run, flush, sck;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] rx_byte;
  int rx_count, bad_count, check_count;
  assign sck = oe ? sck_o : ext_sck;
  cstsio_top u_cstsio_top (.clk(clk), .resetn(resetn), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wait_r), .chip_idle(chip_idle),
    .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(oe), .serial_data_out_pin(sdo),
    .serial_data_in_pin(din), .transfer_interrupt(irq));
  cstsio_peer u_cstsio_peer (.sck(sck), .sdo(sdo), .ext_sck(ext_sck),
    .din(din), .ext_run(ext_run), .flush(flush), .rx_byte(rx_byte),
    .rx_count(rx_count));
  task check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task bus(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
      @(posedge clk);
    while (wait_r !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    check("waitrequest", wait_r, 32'h0);
  endtask : bus
  task wr_reg(logic [3:0] a, logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask : wr_reg
  task rd_chk(string nm, logic [3:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask : rd_chk
  task send(logic [1:0] m, logic [2:0] s, logic [7:0] d);
    wr_reg(CSTSIO_OFS_CTRL, {2'b01, m, 1'b0, s});
    wr_reg(CSTSIO_OFS_DATA, d);
    wr_reg(CSTSIO_OFS_CTRL, {2'b10, m, 1'b0, s});
  endtask : send
  task wait_irq;
    int n;
    n = 0;
    do
      @(negedge clk);
    while (irq !== 1'b1 && ++n < 5000);
    check("interrupt", irq, 32'h1);
  endtask : wait_irq
  task wait_rx(int k, logic [7:0] e);
    int n;
    n = 0;
    while (rx_count < k && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    check("serial byte", rx_byte, e);
  endtask : wait_rx
  task t_reset;
    check("pins", {oe, sck_o, sdo, irq}, 32'hE);
    rd_chk("status", CSTSIO_OFS_STAT, 32'hF3);
    rd_chk("idle", CSTSIO_OFS_IDLE, 32'hBE);
    rd_chk("control", CSTSIO_OFS_CTRL, 32'h08);
    wr_reg(CSTSIO_OFS_DATA, 8'h5A);
    rd_chk("data", CSTSIO_OFS_DATA, 32'h0);
    wr_reg(CSTSIO_OFS_IDLE, 8'h41);
    rd_chk("idle rw", CSTSIO_OFS_IDLE, 32'hFF);
    rd_chk("unmapped", 4'h2, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task t_stream;
    int b;
    b = rx_count;
    send(2'h0, 3'h0, 8'h3C);
    wait_irq;
    rd_chk("busy", CSTSIO_OFS_STAT, 32'hFF);
    wr_reg(CSTSIO_OFS_DATA, 8'h25);
    wait_rx(b + 1, 8'h3C);
    wait_rx(b + 2, 8'h25);
    repeat (40) @(negedge clk);
    check("stall pins", {sck_o, sdo}, 32'h2);
    rd_chk("stall", CSTSIO_OFS_STAT, 32'hFB);
    wr_reg(CSTSIO_OFS_DATA, 8'h81);
    wr_reg(CSTSIO_OFS_CTRL, 8'h00);
    wait_rx(b + 3, 8'h81);
    rd_chk("stopped", CSTSIO_OFS_STAT, 32'hF3);
    $display("test stream done");
  endtask : t_stream
  task t_rates;
    for (int i = 1; i < 7; i++)
    begin
      send(2'(i % 3), 3'(i), 8'(8'h11 * i));
      wr_reg(CSTSIO_OFS_CTRL, {4'(i % 3), 1'b0, 3'(i)});
      wait_rx(rx_count + 1, 8'(8'h11 * i));
      repeat (4) @(negedge clk);
      rd_chk("rate stop", CSTSIO_OFS_STAT, 32'hF3);
      if (i % 3 == 2)
        rd_chk("rate rx", CSTSIO_OFS_DATA, 32'h4B);
    end
    $display("test rates done");
  endtask : t_rates
  task t_rx;
    send(2'h3, 3'h0, 8'h00);
    repeat (200) @(negedge clk);
    rd_chk("rx wait", CSTSIO_OFS_STAT, 32'hFB);
    wr_reg(CSTSIO_OFS_CTRL, 8'h30);
    rd_chk("rx data", CSTSIO_OFS_DATA, 32'h4B);
    rd_chk("rx stop", CSTSIO_OFS_STAT, 32'hF3);
    $display("test receive done");
  endtask : t_rx
  task t_abort;
    send(2'h0, 3'h1, 8'hF0);
    wait_irq;
    wr_reg(CSTSIO_OFS_CTRL, 8'h41);
    rd_chk("aborted", CSTSIO_OFS_STAT, 32'hF3);
    $display("test abort done");
  endtask : t_abort
  task t_idle;
    logic [1:0] s;
    wr_reg(CSTSIO_OFS_IDLE, 8'h00);
    send(2'h0, 3'h0, 8'hC3);
    wait_irq;
    repeat (12) @(posedge clk);
    chip_idle <= 1'b1;
    repeat (2) @(negedge clk);
    s = {sck_o, sdo};
    repeat (40) @(negedge clk);
    check("frozen", {sck_o, sdo}, s);
    @(posedge clk);
    chip_idle <= 1'b0;
    wait_rx(rx_count + 1, 8'hC3);
    wr_reg(CSTSIO_OFS_IDLE, 8'h40);
    chip_idle <= 1'b1;
    send(2'h0, 3'h0, 8'h3A);
    wr_reg(CSTSIO_OFS_CTRL, 8'h00);
    wait_rx(rx_count + 1, 8'h3A);
    @(posedge clk);
    chip_idle <= 1'b0;
    $display("test idle done");
  endtask : t_idle
  task t_ext;
    wr_reg(CSTSIO_OFS_CTRL, 8'h47);
    @(negedge clk);
    check("pin enable", oe, 32'h0);
    wr_reg(CSTSIO_OFS_DATA, 8'h6B);
    wr_reg(CSTSIO_OFS_CTRL, 8'h87);
    wait_irq;
    wr_reg(CSTSIO_OFS_DATA, 8'hD2);
    ext_run = 1'b1;
    @(rx_count);
    check("ext byte", rx_byte, 32'h6B);
    @(rx_count);
    check("ext refill", rx_byte, 32'hD2);
    @(rx_count);
    ext_run = 1'b0;
    check("ext dummy", rx_byte, 32'hD2);
    repeat (10) @(negedge clk);
    rd_chk("dummy stop", CSTSIO_OFS_STAT, 32'hF3);
    $display("test external done");
  endtask : t_ext
  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #900000;
    bad_count++;
    close_out;
  end
  initial
  begin
    {resetn, rd, wr, chip_idle, ext_run, addr, wdata} = '0;
    flush = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    flush <= 1'b0;
    t_reset;
    t_stream;
    t_rates;
    t_rx;
    t_abort;
    t_idle;
    t_ext;
    close_out;
  end
endmodule : cstsio_top_test
